// ===== verilog/fsbp_params.svh
// constants for the flash status and block-protect block
// assumes one 200 MHz core clock and a command front end that decodes the serial protocol
// Function
// [R1] array spans 0000_0000h..07ff_ffffh as 2048 sectors, each 2x32KB and 16x4KB subsectors
// [R2] host reads status with read-status and changes it with write-status
// [R3] control bit 7 set and write-protect low freezes nonvolatile bits, ignores write-status
// [R4] only raising write-protect pin leaves hardware protection
// [R5] bit 7 is nonvolatile write-disable control, default 0 allows status writes
// [R6] bit 5 selects top (0, default) or bottom (1) anchored protected range
// [R7] four-bit protection level in bits 6,4:2; nonzero blocks program/erase in range
// [R8] level 0 none, 1..11 protect 2^(level-1) sectors, 12..15 protect all
// [R9] write enable latch bit 1 clears at power-up, set by write-enable command
// [R10] bit 0 is 1 during write-status, nonvolatile config write, program or erase
// [R11] status bit 0 is always the inverse of flag status ready bit 7
// [R12] die erase runs only when all protection bits are zero
// [R13] flag status bit 7 reads 0 while busy, 1 when ready
// [R14] write enable latch clears when a write operation completes or is rejected; code clears it in the cycle the command is taken
`ifndef FSBP_PARAMS_SVH
`define FSBP_PARAMS_SVH
`define FSBP_SR_WD_BIT      3'd7
`define FSBP_SR_BP3_BIT     3'd6
`define FSBP_SR_TB_BIT      3'd5
`define FSBP_SR_BP_LO_BIT   3'd2
`define FSBP_SR_WEL_BIT     3'd1
`define FSBP_SR_WIP_BIT     3'd0
`define FSBP_SR_NV_MASK     8'hfc
`define FSBP_SR_NV_RESET    8'h00
`define FSBP_FSR_RDY_BIT    3'd7
`define FSBP_SECTOR_LSB     5'd16
`define FSBP_SECTOR_W       11
`define FSBP_LAST_SECTOR    11'h7ff
`define FSBP_LEVEL_ALL      4'hc
`define FSBP_WRSR_TIME_NS   1000
`define FSBP_CLK_PERIOD_NS  5
`define FSBP_WRSR_CYCLES    ((`FSBP_WRSR_TIME_NS + `FSBP_CLK_PERIOD_NS - 1) / `FSBP_CLK_PERIOD_NS)
`endif

// ===== verilog/fsbp_pkg.sv
// types for the flash status and block-protect block
// assumes fsbp_params.svh is included by the design that uses these
package fsbp_pkg;
  typedef enum logic [2:0] {
    FSBP_CMD_NONE,
    FSBP_CMD_WREN,
    FSBP_CMD_WRDI,
    FSBP_CMD_WRSR,
    FSBP_CMD_PROG,
    FSBP_CMD_ERASE,
    FSBP_CMD_DIE_ERASE,
    FSBP_CMD_WRNVCR
  } fsbp_cmd_e;

  typedef enum logic [1:0] {
    FSBP_IDLE,
    FSBP_BUSY_SR,
    FSBP_BUSY_ARRAY
  } fsbp_state_e;

  typedef struct packed {
    fsbp_state_e state;
    logic [7:0]  nv_sr;
    logic        wel;
    logic [7:0]  sr_rd;
    logic        fsr_rdy;
    logic        hw_prot;
    logic        go;
    logic        reject;
    logic [7:0]  pend_sr;
    logic [15:0] cnt;
    logic        wp_m;
    logic        wp_s;
  } fsbp_state_s;
endpackage : fsbp_pkg

// ===== verilog/fsbp_status_protect.sv
// status register, write enable latch and block protection decode
// assumes a command decoder on core_clk_i issues one-cycle cmd_valid_i pulses
`include "fsbp_params.svh"
module fsbp_status_protect #(
  parameter int unsigned WRSR_CYCLES = `FSBP_WRSR_CYCLES
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  write_protect_n_i,
  input  wire logic                  cmd_valid_i,
  input  wire fsbp_pkg::fsbp_cmd_e   cmd_i,
  input  wire logic [7:0]            cmd_wdata_i,
  input  wire logic [26:0]           cmd_addr_i,
  input  wire logic                  array_done_i,
  output logic [7:0]                 status_o,
  output logic                       flag_ready_o,
  output logic                       hw_protect_o,
  output logic                       array_go_o,
  output logic                       reject_o
);
  fsbp_pkg::fsbp_state_s st_r;
  fsbp_pkg::fsbp_state_s st_nxt;

  // true when the sector falls inside the protected range for this level and anchor
  function automatic logic sector_locked(input logic [3:0] lvl, input logic bottom,
                                         input logic [`FSBP_SECTOR_W-1:0] sec);
    logic [`FSBP_SECTOR_W-1:0] span;
    logic                      hit;
    span = '0;
    hit  = 1'b0;
    if (lvl == 4'h0) begin // R8
      hit = 1'b0;
    end else if (lvl >= `FSBP_LEVEL_ALL) begin // R8
      hit = 1'b1;
    end else begin
      span = `FSBP_SECTOR_W'(({{(`FSBP_SECTOR_W-1){1'b0}}, 1'b1} << (lvl - 4'h1)) - 1);
      if (bottom) begin // R6
        hit = (sec <= span);
      end else begin
        hit = (sec >= (`FSBP_LAST_SECTOR - span));
      end
    end
    return hit;
  endfunction : sector_locked

  logic [3:0]                level;
  logic [`FSBP_SECTOR_W-1:0] sector;
  logic                      locked;
  logic                      busy;

  always_comb begin
    level  = {st_r.nv_sr[`FSBP_SR_BP3_BIT], st_r.nv_sr[4:2]}; // R7
    sector = cmd_addr_i[26:16]; // R1
    locked = sector_locked(level, st_r.nv_sr[`FSBP_SR_TB_BIT], sector);
    busy   = (st_r.state != fsbp_pkg::FSBP_IDLE);
  end

  always_comb begin
    st_nxt        = st_r;
    st_nxt.go     = 1'b0;
    st_nxt.reject = 1'b0;
    // pin is asynchronous to the core clock
    st_nxt.wp_m   = write_protect_n_i;
    st_nxt.wp_s   = st_r.wp_m;
    unique case (st_r.state)
      fsbp_pkg::FSBP_IDLE: begin
        if (cmd_valid_i) begin
          unique case (cmd_i)
            fsbp_pkg::FSBP_CMD_WREN: st_nxt.wel = 1'b1; // R9
            fsbp_pkg::FSBP_CMD_WRDI: st_nxt.wel = 1'b0;
            fsbp_pkg::FSBP_CMD_WRSR: begin // R2
              st_nxt.wel = 1'b0; // R14
              if (!st_r.wel || st_r.hw_prot) begin // R3 R9
                st_nxt.reject = 1'b1;
              end else begin
                st_nxt.pend_sr = cmd_wdata_i & `FSBP_SR_NV_MASK;
                st_nxt.cnt     = 16'(WRSR_CYCLES);
                st_nxt.state   = fsbp_pkg::FSBP_BUSY_SR; // R10
              end
            end
            fsbp_pkg::FSBP_CMD_PROG, fsbp_pkg::FSBP_CMD_ERASE: begin
              st_nxt.wel = 1'b0; // R14
              if (!st_r.wel || locked) begin // R7 R9
                st_nxt.reject = 1'b1;
              end else begin
                st_nxt.go    = 1'b1;
                st_nxt.state = fsbp_pkg::FSBP_BUSY_ARRAY; // R10
              end
            end
            fsbp_pkg::FSBP_CMD_DIE_ERASE: begin
              st_nxt.wel = 1'b0; // R14
              if (!st_r.wel || level != 4'h0) begin // R12
                st_nxt.reject = 1'b1;
              end else begin
                st_nxt.go    = 1'b1;
                st_nxt.state = fsbp_pkg::FSBP_BUSY_ARRAY;
              end
            end
            fsbp_pkg::FSBP_CMD_WRNVCR: begin
              st_nxt.wel = 1'b0;
              if (!st_r.wel) begin
                st_nxt.reject = 1'b1;
              end else begin
                st_nxt.go    = 1'b1;
                st_nxt.state = fsbp_pkg::FSBP_BUSY_ARRAY; // R10
              end
            end
            default: begin
            end
          endcase
        end
      end
      fsbp_pkg::FSBP_BUSY_SR: begin
        // a protect event during the write cycle still blocks the commit
        if (st_r.cnt <= 16'h0001) begin
          if (!st_r.hw_prot) begin // R3
            st_nxt.nv_sr = st_r.pend_sr;
          end
          st_nxt.state = fsbp_pkg::FSBP_IDLE;
        end else begin
          st_nxt.cnt = st_r.cnt - 16'h0001;
        end
      end
      fsbp_pkg::FSBP_BUSY_ARRAY: begin
        if (array_done_i) begin
          st_nxt.state = fsbp_pkg::FSBP_IDLE;
        end
      end
      default: st_nxt.state = fsbp_pkg::FSBP_IDLE;
    endcase
    // taken from the next bits so protection never shows with the control bit already cleared
    st_nxt.hw_prot = st_nxt.nv_sr[`FSBP_SR_WD_BIT] & ~st_r.wp_s; // R3 R4 R5
    st_nxt.fsr_rdy = (st_nxt.state == fsbp_pkg::FSBP_IDLE); // R13
    st_nxt.sr_rd   = (st_nxt.nv_sr & `FSBP_SR_NV_MASK)
                   | {6'h00, st_nxt.wel, ~st_nxt.fsr_rdy}; // R10 R11
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_r         <= '0;
      st_r.state   <= fsbp_pkg::FSBP_IDLE;
      st_r.nv_sr   <= `FSBP_SR_NV_RESET;
      st_r.wel     <= 1'b0; // R9
      st_r.fsr_rdy <= 1'b1;
      st_r.wp_m    <= 1'b1;
      st_r.wp_s    <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    status_o     = st_r.sr_rd; // R2
    flag_ready_o = st_r.fsr_rdy;
    hw_protect_o = st_r.hw_prot;
    array_go_o   = st_r.go;
    reject_o     = st_r.reject;
  end

  logic unused_busy;
  assign unused_busy = busy;
endmodule : fsbp_status_protect

// ===== dv/fsbp_status_protect_props.sv
// checker for the status and block-protect ports
// assumes a bind from the bench; one clock, sync reset
module fsbp_status_protect_props #(parameter int unsigned WRSR_CYCLES = 4) (
  input logic core_clk_i, sys_rst_i, write_protect_n_i, cmd_valid_i, array_done_i,
  input fsbp_pkg::fsbp_cmd_e cmd_i,
  input logic [7:0] cmd_wdata_i, status_o,
  input logic [26:0] cmd_addr_i,
  input logic flag_ready_o, hw_protect_o, array_go_o, reject_o
);
  timeunit 1ns; timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire [3:0] lvl = {status_o[6], status_o[4:2]};
  wire take = cmd_valid_i && flag_ready_o;
  sequence s_wrsr_take;
    take && cmd_i == fsbp_pkg::FSBP_CMD_WRSR && status_o[1] && !hw_protect_o;
  endsequence
  sequence s_busy_ready;
    status_o[0] ##[1:300] flag_ready_o;
  endsequence
  a_ready_inverse: assert property (flag_ready_o == !status_o[0]) else $error("ready not inverse of busy");
  a_wrsr_busy: assert property (s_wrsr_take |=> s_busy_ready) else $error("status write busy window wrong");
  a_wel_needed: assert property (take && cmd_i != fsbp_pkg::FSBP_CMD_WREN && cmd_i != fsbp_pkg::FSBP_CMD_WRDI
    && cmd_i != fsbp_pkg::FSBP_CMD_NONE && !status_o[1] |=> reject_o && !array_go_o) else $error("write ran without latch");
  a_hw_freeze: assert property (hw_protect_o ##1 hw_protect_o |-> $stable(status_o[7:2])) else $error("bits moved");
  a_hw_bit7: assert property (hw_protect_o |-> status_o[7]) else $error("protection without control bit");
  a_wrsr_refused: assert property (take && cmd_i == fsbp_pkg::FSBP_CMD_WRSR && hw_protect_o
    |=> reject_o && !status_o[0]) else $error("protected status write ran");
  a_die_level: assert property (take && cmd_i == fsbp_pkg::FSBP_CMD_DIE_ERASE && lvl != 4'h0
    |=> reject_o) else $error("die erase ran with protection");
  a_all_locked: assert property (take && (cmd_i == fsbp_pkg::FSBP_CMD_PROG || cmd_i == fsbp_pkg::FSBP_CMD_ERASE)
    && lvl >= 4'hc |=> reject_o) else $error("array op ran at full lock");
  a_reject_wel: assert property (reject_o |-> !status_o[1]) else $error("latch kept after refusal");
  a_go_busy: assert property (array_go_o |-> status_o[0]) else $error("array start not busy");
endmodule : fsbp_status_protect_props

// ===== dv/fsbp_array_model.sv
// array engine stand-in: each start gets one done pulse after a random delay
// assumes starts arrive as one-cycle pulses, one at a time
module fsbp_array_model (input logic core_clk_i, input logic go_i, output logic done_o);
  timeunit 1ns; timeprecision 1ps;
  initial done_o = 1'b0;
  always @(posedge core_clk_i) begin
    if (go_i === 1'b1) begin
      repeat ($urandom_range(8, 1)) @(posedge core_clk_i);
      done_o <= 1'b1;
      @(posedge core_clk_i);
      done_o <= 1'b0;
    end
  end
endmodule : fsbp_array_model

// ===== dv/fsbp_status_protect_tb.sv
// self-checking bench for the status and block-protect block
// assumes the array model and the checker are compiled alongside
module fsbp_status_protect_tb;
  timeunit 1ns; timeprecision 1ps;
  localparam int unsigned WRSR_CYCLES = 4;
  logic clk = 0, rst = 1, wp_n = 1, cv = 0, done, rdy, hwp, go, rej;
  fsbp_pkg::fsbp_cmd_e cmd = fsbp_pkg::FSBP_CMD_NONE;
  logic [7:0] wd = 8'h00, st;
  logic [26:0] ad = 27'h0;
  logic [1:0] exp_q[$];
  int error_cnt = 0, n_compared = 0;
  always #2.5 clk = ~clk;
  fsbp_status_protect #(.WRSR_CYCLES(WRSR_CYCLES)) i_dut (.core_clk_i(clk), .sys_rst_i(rst), .write_protect_n_i(wp_n),
    .cmd_valid_i(cv), .cmd_i(cmd), .cmd_wdata_i(wd), .cmd_addr_i(ad), .array_done_i(done), .status_o(st),
    .flag_ready_o(rdy), .hw_protect_o(hwp), .array_go_o(go), .reject_o(rej));
  fsbp_array_model i_eng (.core_clk_i(clk), .go_i(go), .done_o(done));
  task chk(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  // waits out busy so the next request is never dropped as ignored
  task send(fsbp_pkg::fsbp_cmd_e c, logic [7:0] d, logic [26:0] a);
    @(posedge clk);
    cv <= 1'b1; cmd <= c; wd <= d; ad <= a;
    @(posedge clk);
    cv <= 1'b0;
    #1;
    repeat (100) if (rdy !== 1'b1) @(posedge clk) #1;
  endtask : send
  task wr(logic [7:0] d, logic [1:0] e);
    send(fsbp_pkg::FSBP_CMD_WREN, 8'h00, 27'h0);
    if (e != 2'b00) exp_q.push_back(e);
    send(fsbp_pkg::FSBP_CMD_WRSR, d, 27'h0);
  endtask : wr
  task op(fsbp_pkg::fsbp_cmd_e c, logic [26:0] a, logic p);
    send(fsbp_pkg::FSBP_CMD_WREN, 8'h00, 27'h0);
    exp_q.push_back(p ? 2'b01 : 2'b10);
    send(c, 8'h00, a);
  endtask : op
  function automatic logic prot(int l, int b, int s);
    int n = (1 << l) >> 1;
    return l == 0 ? 1'b0 : l >= 12 ? 1'b1 : b ? s < n : s >= 2048 - n;
  endfunction : prot
  always @(negedge clk) if (go === 1'b1 || rej === 1'b1)
    chk("answer", exp_q.size() ? exp_q.pop_front() : 2'b00, {go, rej});
  initial begin
    int l, b, s, n;
    void'($urandom(96322));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk) #1;
    chk("status", 8'h00, st);
    exp_q.push_back(2'b01);
    send(fsbp_pkg::FSBP_CMD_PROG, 8'h00, 27'h0);
    $display("reset test done");
    for (int i = 0; i < 32; i++) begin
      l = i % 16; b = i / 16; n = (1 << l) >> 1;
      wr({1'b0, l[3], b[0], l[2:0], 2'b00}, 2'b00);
      chk("status", {1'b0, l[3], b[0], l[2:0], 2'b00}, st);
      for (int k = 0; k < 2; k++) begin
        s = (b ? n - k : 2047 - n + k) & 2047;
        op(k ? fsbp_pkg::FSBP_CMD_ERASE : fsbp_pkg::FSBP_CMD_PROG, {s[10:0], 16'($urandom)}, prot(l, b, s));
      end
    end
    $display("level sweep done");
    op(fsbp_pkg::FSBP_CMD_DIE_ERASE, 27'h0, 1'b1);
    wr(8'h80, 2'b00);
    op(fsbp_pkg::FSBP_CMD_DIE_ERASE, 27'h0, 1'b0);
    $display("die erase test done");
    send(fsbp_pkg::FSBP_CMD_WREN, 8'h00, 27'h0);
    exp_q.push_back(2'b01);
    send(fsbp_pkg::FSBP_CMD_WRDI, 8'h00, 27'h0);
    send(fsbp_pkg::FSBP_CMD_PROG, 8'h00, 27'h0);
    op(fsbp_pkg::FSBP_CMD_WRNVCR, 27'h0, 1'b0);
    chk("status", 8'h80, st);
    $display("latch test done");
    @(posedge clk) wp_n <= 1'b0;
    repeat (4) @(posedge clk) #1;
    chk("hw_protect", 8'h01, hwp);
    wr(8'h00, 2'b01);
    chk("status", 8'h80, st);
    @(posedge clk) wp_n <= 1'b1;
    repeat (4) @(posedge clk) #1;
    chk("hw_protect", 8'h00, hwp);
    wr(8'h00, 2'b00);
    chk("status", 8'h00, st);
    chk("queue", 8'h00, 8'(exp_q.size()));
    $display("pin test done");
    conclude;
  end
  initial begin
    #100000;
    error_cnt++;
    conclude;
  end
endmodule : fsbp_status_protect_tb
bind fsbp_status_protect fsbp_status_protect_props #(.WRSR_CYCLES(WRSR_CYCLES)) i_props (.*);
